// File: common/dsg_consts.svh
// Purpose: Register map, field layout and timing constants of the
//          diagnostic signal generator.
// Assumes: 16-bit registers, each on one aligned 32-bit APB word.
// Notes:   Byte address is four times the register index.
`ifndef DSG_CONSTS_SVH
`define DSG_CONSTS_SVH

`define DSG_IDX_W          12
`define DSG_IDX_START_EVT  12'h036
`define DSG_IDX_CONTROL    12'h116
`define DSG_IDX_STATUS     12'h118

`define DSG_REG_W          16
`define DSG_CTRL_RST       16'h0000
`define DSG_CTRL_WMASK     16'h7fff
`define DSG_START_RST      16'h0000
`define DSG_START_WMASK    16'h03ff

`define DSG_DELAY_W        12
`define DSG_DELAY_MSB      11
`define DSG_ENABLE_BIT     12
`define DSG_TRAIN_BIT      13
`define DSG_FREQ_BIT       14

`define DSG_EVT_W          8
`define DSG_EVT_MSB        7
`define DSG_TRAIN_PULSES   84
`define DSG_TOGGLE_W       8

`define DSG_SYS_KHZ        125000
`define DSG_BUCKET_KHZ     53000
`define DSG_LOW_KHZ        2500
`define DSG_PHASE_W        24
`define DSG_BIT_DIV        16

`endif

// File: common/dsg_evt_if.sv
// Purpose: Decoded beam-sync event code passed to the generator core.
// Assumes: Same clock on both sides.
// Notes:   valid is a one-cycle pulse; code stands until the next pulse.
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
interface dsg_evt_if;
    logic [`DSG_EVT_MSB:0] code;
    logic                  valid;
    modport src (output code, output valid);
    modport snk (input code, input valid);
endinterface : dsg_evt_if
`default_nettype wire

// File: common/dsg_pkg.sv
// Purpose: Types shared by the diagnostic signal generator modules.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are written out for readable waveforms.
`default_nettype none
package dsg_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN   = 2'b10
    } dsg_state_t;

    typedef enum logic [1:0]
    {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b10,
        RX_STOP  = 2'b11
    } dsg_rx_state_t;

endpackage : dsg_pkg
`default_nettype wire

// File: rtl/dsg_beam_sync_rx.sv
// Purpose: Decodes event codes from the beam-sync serial link.
// Assumes: Idle high, one low start bit, 8 data bits LSB first,
//          one high stop bit, BIT_DIV system clocks per bit.
// Notes:   A frame with a low stop bit is dropped silently.
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
module dsg_beam_sync_rx
    import dsg_pkg::*;
#(
    parameter int BIT_DIV = `DSG_BIT_DIV
)
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  beamSyncSerialLink,
    dsg_evt_if.src     evt
);
    logic                  sync1_r;
    logic                  sync2_r;
    logic                  sync3_r;
    logic                  line_r;
    dsg_rx_state_t         rxState_r;
    logic [15:0]           baud_r;
    logic [3:0]            bitCnt_r;
    logic [`DSG_EVT_MSB:0] shift_r;
    logic                  bitTick;

    localparam logic [15:0] FULL = 16'(BIT_DIV - 1);
    localparam logic [15:0] HALF = 16'(BIT_DIV / 2 - 1);

    // Pin crosses in; filtered level moves only when stages 2 and 3 agree
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
            line_r  <= 1'b1;
        end
        else
        begin
            sync1_r <= beamSyncSerialLink;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (sync2_r == sync3_r)
                line_r <= sync3_r;
        end
    end

    assign bitTick = (baud_r == 16'h0000);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rxState_r <= RX_IDLE;
            baud_r    <= 16'h0000;
            bitCnt_r  <= 4'h0;
            shift_r   <= 8'h00;
        end
        else
        begin
            if (!bitTick)
                baud_r <= baud_r - 16'h0001;
            case (rxState_r)
                RX_IDLE:
                    if (!line_r)
                    begin
                        rxState_r <= RX_START;
                        baud_r    <= HALF;
                    end
                RX_START:
                    if (bitTick)
                    begin
                        // Sample points sit mid-bit from here on
                        rxState_r <= line_r ? RX_IDLE : RX_DATA;
                        baud_r    <= FULL;
                        bitCnt_r  <= 4'h0;
                    end
                RX_DATA:
                    if (bitTick)
                    begin
                        shift_r  <= {line_r, shift_r[`DSG_EVT_MSB:1]};
                        baud_r   <= FULL;
                        bitCnt_r <= bitCnt_r + 4'h1;
                        if (bitCnt_r == 4'(`DSG_EVT_W - 1))
                            rxState_r <= RX_STOP;
                    end
                RX_STOP:
                    if (bitTick)
                        rxState_r <= RX_IDLE;
                default:
                    rxState_r <= RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            evt.valid <= 1'b0;
            evt.code  <= 8'h00;
        end
        else
        begin
            evt.valid <= (rxState_r == RX_STOP) && bitTick && line_r;
            if ((rxState_r == RX_STOP) && bitTick && line_r)
                evt.code <= shift_r;
        end
    end

endmodule : dsg_beam_sync_rx
`default_nettype wire

// File: rtl/dsg_top.sv
// Purpose: Diagnostic signal generator for the front-end channel cards,
//          with its APB register file and beam-sync event decoder.
// Assumes: One 125 MHz clock; bucket and low rates come from phase
//          accumulators as one-cycle enables.
// Notes:   Output edges jitter by one system clock against the ideal
//          53 MHz grid; a true 53 MHz needs the accelerator clock.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
module dsg_top
    import dsg_pkg::*;
#(
    parameter int BIT_DIV      = `DSG_BIT_DIV,
    parameter int TRAIN_PULSES = `DSG_TRAIN_PULSES
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        beamSyncSerialLink,
    output var  logic        frontEndChannelDiag,
    output logic             diagActive
);
    localparam logic [`DSG_TOGGLE_W-1:0] LAST_TOGGLE =
        `DSG_TOGGLE_W'(2 * TRAIN_PULSES - 1);

    dsg_evt_if evt ();

    dsg_state_t               state_r;
    logic [`DSG_REG_W-1:0]    ctrl_r;
    logic [`DSG_REG_W-1:0]    startEvt_r;
    logic [`DSG_DELAY_MSB:0]  delayCnt_r;
    logic [`DSG_TOGGLE_W-1:0] toggleCnt_r;
    logic [`DSG_EVT_MSB:0]    lastEvt_r;
    logic [`DSG_PHASE_W-1:0]  phase_r [2];
    logic [1:0]               tick;
    logic                     halfTick;
    logic                     freqTick;
    logic                     enable;
    logic                     trainMode;
    logic                     evtHit;
    logic                     restart;
    logic                     delayDone;
    logic                     trainDone;
    logic                     access;
    logic                     mapped;
    logic [`DSG_REG_W-1:0]    rdMux;

    function automatic logic regHit(input logic [15:0] addr,
                                    input logic [`DSG_IDX_W-1:0] idx);
        regHit = (addr == {2'b00, idx, 2'b00});
    endfunction : regHit

    function automatic logic [`DSG_PHASE_W-1:0] phaseInc(input int khz);
        longint num;
        num = longint'(2 * khz) << `DSG_PHASE_W;
        phaseInc = `DSG_PHASE_W'(num / `DSG_SYS_KHZ);
    endfunction : phaseInc

    dsg_beam_sync_rx #(
        .BIT_DIV            (BIT_DIV)
    ) u_rx (
        .sys_clk            (sys_clk),
        .rst                (rst),
        .beamSyncSerialLink (beamSyncSerialLink),
        .evt                (evt)
    );

    // Tick 0 is the half-bucket rate, tick 1 twice the low frequency
    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_tick
            localparam logic [`DSG_PHASE_W-1:0] INC =
                phaseInc(g == 0 ? `DSG_BUCKET_KHZ : `DSG_LOW_KHZ);
            logic [`DSG_PHASE_W:0] sum;
            assign sum     = {1'b0, phase_r[g]} + {1'b0, INC};
            assign tick[g] = sum[`DSG_PHASE_W];
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                    phase_r[g] <= '0;
                else
                    phase_r[g] <= sum[`DSG_PHASE_W-1:0];
            end
        end
    endgenerate

    assign halfTick  = tick[0];
    assign freqTick  = ctrl_r[`DSG_FREQ_BIT] ? tick[1] : tick[0];
    assign enable    = ctrl_r[`DSG_ENABLE_BIT];
    assign trainMode = ctrl_r[`DSG_TRAIN_BIT];
    assign evtHit    = evt.valid &&
                       (evt.code == startEvt_r[`DSG_EVT_MSB:0]);
    // Continuous output is not disturbed by later events
    assign restart   = enable && evtHit &&
                       ((state_r == ST_IDLE) || trainMode);
    assign delayDone = halfTick && (state_r == ST_DELAY) &&
                       (delayCnt_r == `DSG_DELAY_W'(1));
    assign trainDone = (state_r == ST_RUN) && trainMode && freqTick &&
                       (toggleCnt_r == LAST_TOGGLE);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_r <= ST_IDLE;
        else if (!enable)
            state_r <= ST_IDLE;
        else if (restart)
            state_r <= (ctrl_r[`DSG_DELAY_MSB:0] == '0) ? ST_RUN
                                                        : ST_DELAY;
        else if (delayDone)
            state_r <= ST_RUN;
        else if (trainDone)
            state_r <= ST_IDLE;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            delayCnt_r <= '0;
        else if (restart)
            delayCnt_r <= ctrl_r[`DSG_DELAY_MSB:0];
        else if (halfTick && (state_r == ST_DELAY))
            delayCnt_r <= delayCnt_r - `DSG_DELAY_W'(1);
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            toggleCnt_r <= '0;
        else if (restart || (state_r != ST_RUN))
            toggleCnt_r <= '0;
        else if (freqTick)
            toggleCnt_r <= toggleCnt_r + `DSG_TOGGLE_W'(1);
    end

    // Even toggle count, so a finished burst always parks low
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            frontEndChannelDiag <= 1'b0;
        else if (!enable || restart || (state_r != ST_RUN))
            frontEndChannelDiag <= 1'b0;
        else if (freqTick)
            frontEndChannelDiag <= !frontEndChannelDiag;
    end

    assign diagActive = (state_r == ST_RUN);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            lastEvt_r <= '0;
        else if (evt.valid)
            lastEvt_r <= evt.code;
    end

    // APB slave, zero wait states
    assign access  = psel && penable;
    assign pready  = access;
    assign mapped  = regHit(paddr, `DSG_IDX_CONTROL) ||
                     regHit(paddr, `DSG_IDX_START_EVT) ||
                     regHit(paddr, `DSG_IDX_STATUS);
    assign pslverr = access && !mapped;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r     <= `DSG_CTRL_RST;
            startEvt_r <= `DSG_START_RST;
        end
        else if (access && pwrite)
        begin
            if (regHit(paddr, `DSG_IDX_CONTROL))
                ctrl_r <= pwdata[`DSG_REG_W-1:0] & `DSG_CTRL_WMASK;
            else if (regHit(paddr, `DSG_IDX_START_EVT))
                startEvt_r <= pwdata[`DSG_REG_W-1:0] & `DSG_START_WMASK;
        end
    end

    always_comb
    begin
        if (regHit(paddr, `DSG_IDX_CONTROL))
            rdMux = ctrl_r;
        else if (regHit(paddr, `DSG_IDX_START_EVT))
            rdMux = startEvt_r;
        else if (regHit(paddr, `DSG_IDX_STATUS))
            rdMux = {lastEvt_r, 5'h00, frontEndChannelDiag, state_r};
        else
            rdMux = 16'h0000;
    end

    // Read data registered in the setup cycle, valid in the access cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= {16'h0000, rdMux};
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_burst_event;
        enable && trainMode && evtHit;
    endsequence

    sequence s_burst_cleared;
        (toggleCnt_r == '0) && !frontEndChannelDiag;
    endsequence

    property p_disabled_quiet;
        !enable |=> (state_r == ST_IDLE) && !frontEndChannelDiag;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("Output active while disabled");

    property p_delay_load;
        restart && (ctrl_r[`DSG_DELAY_MSB:0] != '0) |=>
            (state_r == ST_DELAY) &&
            (delayCnt_r == $past(ctrl_r[`DSG_DELAY_MSB:0]));
    endproperty
    a_delay_load: assert property (p_delay_load)
        else $error("Delay not loaded on start event");

    property p_delay_quiet;
        (state_r == ST_DELAY) |-> !frontEndChannelDiag;
    endproperty
    a_delay_quiet: assert property (p_delay_quiet)
        else $error("Output moved during delay");

    property p_cont_toggle;
        (state_r == ST_RUN) && !trainMode && enable && freqTick |=>
            frontEndChannelDiag != $past(frontEndChannelDiag);
    endproperty
    a_cont_toggle: assert property (p_cont_toggle)
        else $error("Continuous output missed a toggle");

    property p_train_end;
        trainDone && enable |=> (state_r == ST_IDLE) ##0
            !frontEndChannelDiag;
    endproperty
    a_train_end: assert property (p_train_end)
        else $error("Burst did not end low");

    property p_freq_hold;
        enable && !restart && !freqTick |=> $stable(frontEndChannelDiag);
    endproperty
    a_freq_hold: assert property (p_freq_hold)
        else $error("Output moved without a frequency tick");

    property p_no_match;
        (state_r == ST_IDLE) && enable && !evt.valid |=>
            state_r == ST_IDLE;
    endproperty
    a_no_match: assert property (p_no_match)
        else $error("Left idle without a start event");

    property p_restart;
        s_burst_event |=> s_burst_cleared;
    endproperty
    a_restart: assert property (p_restart)
        else $error("Start event did not restart the burst");

    sequence s_delay_expiry;
        enable && !evtHit && delayDone;
    endsequence

    property p_delay_expiry;
        s_delay_expiry |=> (state_r == ST_RUN) && !frontEndChannelDiag;
    endproperty
    a_delay_expiry: assert property (p_delay_expiry)
        else $error("Delay expiry did not start the output");

    property p_zero_delay;
        restart && (ctrl_r[`DSG_DELAY_MSB:0] == '0) |=>
            (state_r == ST_RUN) && (toggleCnt_r == '0);
    endproperty
    a_zero_delay: assert property (p_zero_delay)
        else $error("Zero delay did not start at once");

    property p_idle_low;
        (state_r == ST_IDLE) |-> !frontEndChannelDiag;
    endproperty
    a_idle_low: assert property (p_idle_low)
        else $error("Output not low while idle");

    // Low rate must follow its own tick, not the half-bucket one
    property p_low_rate;
        enable && ctrl_r[`DSG_FREQ_BIT] && (state_r == ST_RUN) &&
            !restart && !tick[1] |=> $stable(frontEndChannelDiag);
    endproperty
    a_low_rate: assert property (p_low_rate)
        else $error("Low rate output moved off its tick");

endmodule : dsg_top
`default_nettype wire

// File: verif/diagnostic_signal_generator_tb.sv
// Purpose: Self-checking bench of the diagnostic signal generator.
// Assumes: Zero wait APB, BIT_DIV of 4, full burst of 84 pulses.
// Notes:   Rates are judged by clock counts with small tolerances.
`timescale 1ns/1ps
`default_nettype none
`include "dsg_consts.svh"
module diagnostic_signal_generator_tb;
    import dsg_pkg::*;
    localparam int          BITDIV  = 4;
    localparam logic [15:0] A_START = 16'h00d8;
    localparam logic [15:0] A_CTRL  = 16'h0458;
    localparam logic [15:0] A_STAT  = 16'h0460;

    logic        sys_clk = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [15:0] paddr   = 16'h0000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    wire  logic  line;
    logic        diag;
    logic        active;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          seed       = 35215;
    logic [31:0] q;
    logic        e;
    logic [7:0]  code;
    logic [11:0] dly;
    int          t0;
    int          t1;
    int          len;
    int          base;

    dsg_top #(.BIT_DIV(BITDIV), .TRAIN_PULSES(84)) dsg_top_i (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .beamSyncSerialLink(line),
        .frontEndChannelDiag(diag), .diagActive(active));

    dsg_fec_model #(.BIT_DIV(BITDIV)) dsg_fec_model_i (
        .sys_clk(sys_clk), .frontEndChannelDiag(diag),
        .beamSyncSerialLink(line));

    always #4 sys_clk = ~sys_clk;

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // Only pready or the bench timeout may end this wait
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic in_tol(int seen, int exp, int tol);
        return (seen >= exp - tol) && (seen <= exp + tol);
    endfunction : in_tol

    // Expected clocks for n half-bucket ticks
    function automatic int delay_clocks(int n);
        return n * `DSG_SYS_KHZ / (2 * `DSG_BUCKET_KHZ);
    endfunction : delay_clocks

    function automatic int burst_clocks(logic low);
        return `DSG_TRAIN_PULSES * `DSG_SYS_KHZ /
               (low ? `DSG_LOW_KHZ : `DSG_BUCKET_KHZ);
    endfunction : burst_clocks

    // Event, then clocks to first high and clocks spent running
    task automatic fire(input logic [7:0] c, output int ts, output int tl);
        dsg_fec_model_i.send(c);
        ts = 0;
        tl = 0;
        @(negedge sys_clk);
        while (diag !== 1'b1 && ts < 2000)
        begin
            @(negedge sys_clk);
            ts++;
        end
        while (active === 1'b1 && tl < 5000)
        begin
            @(negedge sys_clk);
            tl++;
        end
    endtask : fire

    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, A_CTRL, 32'h0, q, e);
        check("ctrl_reset", q, 32'h0);
        apb(1'b0, A_START, 32'h0, q, e);
        check("start_reset", q, 32'h0);
        check("diag_reset", {31'h0, diag}, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            t0 = $random(seed);
            apb(1'b1, A_CTRL, t0, q, e);
            apb(1'b0, A_CTRL, 32'h0, q, e);
            check("ctrl_rw", q, t0 & 32'h7fff);
            apb(1'b1, A_START, t0, q, e);
            apb(1'b0, A_START, 32'h0, q, e);
            check("start_rw", q, t0 & 32'h03ff);
        end
        apb(1'b1, A_CTRL, 32'h0, q, e);
        apb(1'b0, 16'h0ffc, 32'h0, q, e);
        check("unmapped_err", {31'h0, e}, 32'h1);
        check("unmapped_data", q, 32'h0);
        code = 8'($random(seed));
        apb(1'b1, A_START, {24'h0, code}, q, e);
        // Disabled train: nothing leaves the block
        base = dsg_fec_model_i.riseCount;
        apb(1'b1, A_CTRL, 32'h2000, q, e);
        fire(code, t0, len);
        check("disabled", dsg_fec_model_i.riseCount - base, 0);
        // Wrong code must not start
        apb(1'b1, A_CTRL, 32'h3000, q, e);
        base = dsg_fec_model_i.riseCount;
        fire(code ^ 8'h5a, t0, len);
        check("mismatch", dsg_fec_model_i.riseCount - base, 0);
        // Fast burst with zero delay, slow burst with a random delay
        for (int f = 0; f < 2; f++)
        begin
            dly = (f == 0) ? 12'h000 : 12'($random(seed) & 32'h3f);
            apb(1'b1, A_CTRL, {16'h0, 1'b0, f[0], 2'b11, dly}, q, e);
            base = dsg_fec_model_i.riseCount;
            fire(code, t1, len);
            // Zero delay fast burst is the reference for the delay test
            if (f == 0)
                t0 = t1;
            repeat (4) @(negedge sys_clk);
            check("pulses", dsg_fec_model_i.riseCount - base, 84);
            check("burst_len", in_tol(len, burst_clocks(f[0]),
                  burst_clocks(f[0]) / 25), 1);
            check("idle_low", {31'h0, diag}, 32'h0);
        end
        apb(1'b1, A_CTRL, 32'h31f4, q, e);
        fire(code, t1, len);
        check("delay", in_tol(t1 - t0, delay_clocks(500), 4), 1);
        // Second event mid-burst restarts delay, output held low
        apb(1'b1, A_CTRL, 32'h3064, q, e);
        dsg_fec_model_i.send(code);
        repeat (180) @(negedge sys_clk);
        dsg_fec_model_i.send(code);
        repeat (20) @(negedge sys_clk);
        check("restart_low", {30'h0, diag, active}, 32'h0);
        base = dsg_fec_model_i.riseCount;
        repeat (400) @(negedge sys_clk);
        check("restart_n", dsg_fec_model_i.riseCount - base, 84);
        // Continuous fast mode, then disable forces low
        apb(1'b1, A_CTRL, 32'h1000, q, e);
        fire(code, t0, len);
        base = dsg_fec_model_i.riseCount;
        repeat (500) @(negedge sys_clk);
        check("cont_rate", in_tol(dsg_fec_model_i.riseCount - base,
              500 * `DSG_BUCKET_KHZ / `DSG_SYS_KHZ, 3), 1);
        apb(1'b0, A_STAT, 32'h0, q, e);
        check("status_run", q & 32'h3, 32'h2);
        check("status_evt", {24'h0, q[15:8]}, {24'h0, code});
        apb(1'b1, A_CTRL, 32'h0, q, e);
        repeat (4) @(negedge sys_clk);
        check("disable_low", {30'h0, diag, active}, 32'h0);
        end_of_test();
    end
endmodule : diagnostic_signal_generator_tb
`default_nettype wire

// File: verif/dsg_fec_model.sv
// Purpose: Far side model: beam-sync frame source, channel card input.
// Assumes: 8N1 frames LSB first, BIT_DIV clocks a bit, idle high.
// Notes:   Counts rising edges of the diagnostic line, never resets them.
`timescale 1ns/1ps
`default_nettype none
module dsg_fec_model
#(
    parameter int BIT_DIV = 4
)
(
    input  wire logic sys_clk,
    input  wire logic frontEndChannelDiag,
    output var  logic beamSyncSerialLink
);
    int   riseCount = 0;
    logic prevDiag  = 1'b0;

    initial beamSyncSerialLink = 1'b1;

    always @(posedge sys_clk)
    begin
        prevDiag <= frontEndChannelDiag;
        if (frontEndChannelDiag === 1'b1 && prevDiag === 1'b0)
            riseCount <= riseCount + 1;
    end

    // One frame: start, eight data bits, stop
    task automatic send(input logic [7:0] code);
        logic [9:0] frame;
        frame = {1'b1, code, 1'b0};
        for (int b = 0; b < 10; b++)
        begin
            @(posedge sys_clk);
            beamSyncSerialLink <= frame[b];
            repeat (BIT_DIV - 1) @(posedge sys_clk);
        end
    endtask : send
endmodule : dsg_fec_model
`default_nettype wire
